// ---- common/flash_host_pkg.sv ----
package flash_host_pkg;

   // bus widths of the widest part in the family
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;

   // clock and pin timing; least times round up to whole cycles
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_WE_LOW_NS   = 60;   // least write pulse width
   localparam int T_ACCESS_NS   = 110;  // output valid after select
   localparam int T_RESET_NS    = 100;  // least reset pulse width
   localparam int T_WAKE_NS     = 600;  // wait after reset release
   localparam logic [7:0] WE_CYC =
      8'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // access time plus two cycles spent in the data synchroniser
   localparam logic [7:0] RD_CYC =
      8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2);
   localparam logic [7:0] RST_CYC =
      8'((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] WAKE_CYC =
      8'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // command codes written to the command_interface
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_PROGRAM    = 8'h40;
   localparam logic [7:0] CMD_ERASE      = 8'h20;

   // status byte layout
   localparam int STAT_READY_BIT = 7;
   localparam logic [7:0] STAT_ERR_MASK = 8'h32;

   // block organisation, bottom parameter blocks, in words
   localparam int PARAM_BLOCKS = 8;
   localparam int PARAM_WORDS  = 4096;
   localparam int MAIN_WORDS   = 32768;
   localparam logic [21:0] PARAM_MASK = 22'(PARAM_WORDS - 1);
   localparam logic [21:0] MAIN_MASK  = 22'(MAIN_WORDS - 1);
   localparam logic [21:0] PARAM_TOP  = 22'(PARAM_BLOCKS * PARAM_WORDS);

   localparam logic [15:0] DQ_OE_WORD = 16'hffff;
   localparam logic [15:0] DQ_OE_BYTE = 16'h00ff;

   typedef enum logic [2:0] {
      OP_READ    = 3'h0,
      OP_WRITE   = 3'h1,
      OP_PROGRAM = 3'h2,
      OP_ERASE   = 3'h3,
      OP_SETMODE = 3'h4,
      OP_RESET   = 3'h5
   } op_t;

   typedef enum logic [1:0] {
      MODE_ARRAY  = 2'h0,
      MODE_ID     = 2'h1,
      MODE_STATUS = 2'h2,
      MODE_QUERY  = 2'h3
   } mode_t;

   typedef struct packed {
      op_t         op;
      mode_t       mode;   // read mode entered by OP_SETMODE
      logic [21:0] addr;
      logic [15:0] data;   // write data, command or erase confirm
   } req_t;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_SETUP = 9'h002,
      ST_WELO  = 9'h004,
      ST_WEHI  = 9'h008,
      ST_GAP   = 9'h010,
      ST_RDLO  = 9'h020,
      ST_REND  = 9'h040,
      ST_RSTLO = 9'h080,
      ST_RSTWK = 9'h100
   } state_t;

endpackage

// ---- rtl/flash_host.sv ----
`timescale 1ns/1ns
// How it works
// - read strobes select, enable outputs, write high
// - write is select low, output high, write low
// - write protect held high for program, erase
// - read mode changes by its command, to status for program, erase, to array on reset
module flash_host (
   input  wire logic                   CLK_IN,
   input  wire logic                   RST_IN,
   input  wire logic                   REQ_IN,
   input  wire flash_host_pkg::req_t   REQ_DATA_IN,
   input  wire logic                   BYTE_MODE_IN,
   input  wire logic                   VPP_OK_IN,
   input  wire logic [15:0]            DQ_IN,
   output logic                        BUSY_OUT,
   output logic                        DONE_OUT,
   output logic                        ERR_OUT,
   output logic [15:0]                 RDATA_OUT,
   output flash_host_pkg::mode_t       MODE_OUT,
   output logic                        CE_N_OUT,
   output logic                        OE_N_OUT,
   output logic                        WE_N_OUT,
   output logic                        RESET_POWERDOWN_N_OUT,
   output logic                        WP_OUT,
   output logic [21:0]                 ADDR_OUT,
   output logic [15:0]                 DQ_OUT,
   output logic [15:0]                 DQ_OE_OUT
);
   import flash_host_pkg::*;
   default clocking chk_clk @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   state_t      state_r;     // sequencer state
   logic [7:0]  cnt_r;       // cycles left in a timed phase
   req_t        req_r;       // request under way
   logic        second_r;    // a second write pulse is pending
   logic        poll_r;      // status polling follows the writes
   logic        byte_r;      // byte-wide part, caught at accept
   logic [15:0] dq_s1_r;     // data synchroniser, first stage
   logic [15:0] dq_s2_r;     // data synchroniser, second stage
   logic        vpp_s1_r;    // supply monitor synchroniser
   logic        vpp_s2_r;
   logic [15:0] oe_mask;     // lanes the host may drive
   logic [21:0] blk_base;    // erase target rounded to its block

   assign oe_mask = byte_r ? DQ_OE_BYTE : DQ_OE_WORD;

   // parameter blocks sit at the bottom; above them main blocks
   assign blk_base = (REQ_DATA_IN.addr < PARAM_TOP) ?
                     (REQ_DATA_IN.addr & ~PARAM_MASK) :
                     (REQ_DATA_IN.addr & ~MAIN_MASK);

   // pins from the device and the supply monitor are asynchronous
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         dq_s1_r  <= 16'h0000;
         dq_s2_r  <= 16'h0000;
         vpp_s1_r <= 1'b0;
         vpp_s2_r <= 1'b0;
      end else begin
         dq_s1_r  <= DQ_IN;
         dq_s2_r  <= dq_s1_r;
         vpp_s1_r <= VPP_OK_IN;
         vpp_s2_r <= vpp_s1_r;
      end
   end

   // sequencer and pin drivers; reset opens with a device reset so
   // the part is known to be in read-array mode afterwards
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state_r               <= ST_RSTLO;
         cnt_r                 <= RST_CYC - 8'h01;
         req_r                 <= '0;
         second_r              <= 1'b0;
         poll_r                <= 1'b0;
         byte_r                <= 1'b0;
         BUSY_OUT              <= 1'b1;
         DONE_OUT              <= 1'b0;
         ERR_OUT               <= 1'b0;
         RDATA_OUT             <= 16'h0000;
         MODE_OUT              <= MODE_ARRAY;
         CE_N_OUT              <= 1'b1;
         OE_N_OUT              <= 1'b1;
         WE_N_OUT              <= 1'b1;
         RESET_POWERDOWN_N_OUT <= 1'b0;
         WP_OUT                <= 1'b0;
         ADDR_OUT              <= 22'h000000;
         DQ_OUT                <= 16'h0000;
         DQ_OE_OUT             <= 16'h0000;
      end else begin
         DONE_OUT <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (REQ_IN) begin
                  req_r    <= REQ_DATA_IN;
                  byte_r   <= BYTE_MODE_IN;
                  ERR_OUT  <= 1'b0;
                  BUSY_OUT <= 1'b1;
                  second_r <= 1'b0;
                  poll_r   <= 1'b0;
                  case (REQ_DATA_IN.op)
                     OP_RESET: begin
                        RESET_POWERDOWN_N_OUT <= 1'b0;
                        cnt_r   <= RST_CYC - 8'h01;
                        state_r <= ST_RSTLO;
                     end
                     OP_READ: begin
                        // identifier codes need upper address zero
                        ADDR_OUT <= (MODE_OUT == MODE_ID) ?
                           {21'h000000, REQ_DATA_IN.addr[0]} :
                           REQ_DATA_IN.addr;
                        CE_N_OUT <= 1'b0;
                        OE_N_OUT <= 1'b0;
                        cnt_r    <= RD_CYC - 8'h01;
                        state_r  <= ST_RDLO;
                     end
                     OP_PROGRAM, OP_ERASE: begin
                        if (!vpp_s2_r) begin
                           // device would fail it; refuse up front
                           ERR_OUT  <= 1'b1;
                           DONE_OUT <= 1'b1;
                           BUSY_OUT <= 1'b0;
                        end else begin
                           WP_OUT   <= 1'b1;
                           second_r <= 1'b1;
                           poll_r   <= 1'b1;
                           ADDR_OUT <= (REQ_DATA_IN.op == OP_ERASE) ?
                                       blk_base : REQ_DATA_IN.addr;
                           DQ_OUT   <= {8'h00,
                              (REQ_DATA_IN.op == OP_ERASE) ?
                              CMD_ERASE : CMD_PROGRAM};
                           DQ_OE_OUT <= BYTE_MODE_IN ?
                                        DQ_OE_BYTE : DQ_OE_WORD;
                           CE_N_OUT <= 1'b0;
                           state_r  <= ST_SETUP;
                        end
                     end
                     default: begin
                        // single bus write: plain data or mode command
                        ADDR_OUT  <= REQ_DATA_IN.addr;
                        DQ_OUT    <= REQ_DATA_IN.data;
                        DQ_OE_OUT <= BYTE_MODE_IN ?
                                     DQ_OE_BYTE : DQ_OE_WORD;
                        CE_N_OUT  <= 1'b0;
                        state_r   <= ST_SETUP;
                     end
                  endcase
               end
            end
            ST_SETUP: begin
               // output enable stays high for the whole write
               WE_N_OUT <= 1'b0;
               cnt_r    <= WE_CYC - 8'h01;
               state_r  <= ST_WELO;
            end
            ST_WELO: begin
               if (cnt_r == 8'h00) begin
                  WE_N_OUT <= 1'b1;
                  state_r  <= ST_WEHI;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ST_WEHI: begin
               // data held one cycle past the rising edge
               CE_N_OUT  <= 1'b1;
               DQ_OE_OUT <= 16'h0000;
               state_r   <= ST_GAP;
            end
            ST_GAP: begin
               if (second_r) begin
                  // program data or erase confirm, same address
                  second_r  <= 1'b0;
                  DQ_OUT    <= req_r.data;
                  DQ_OE_OUT <= oe_mask;
                  CE_N_OUT  <= 1'b0;
                  state_r   <= ST_SETUP;
               end else if (poll_r) begin
                  // device answers status while it is busy
                  MODE_OUT <= MODE_STATUS;
                  CE_N_OUT <= 1'b0;
                  OE_N_OUT <= 1'b0;
                  cnt_r    <= RD_CYC - 8'h01;
                  state_r  <= ST_RDLO;
               end else begin
                  if (req_r.op == OP_SETMODE) begin
                     MODE_OUT <= req_r.mode;
                  end
                  DONE_OUT <= 1'b1;
                  BUSY_OUT <= 1'b0;
                  state_r  <= ST_IDLE;
               end
            end
            ST_RDLO: begin
               if (cnt_r == 8'h00) begin
                  RDATA_OUT <= dq_s2_r & oe_mask;
                  CE_N_OUT  <= 1'b1;
                  OE_N_OUT  <= 1'b1;
                  state_r   <= ST_REND;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ST_REND: begin
               if (!poll_r) begin
                  DONE_OUT <= 1'b1;
                  BUSY_OUT <= 1'b0;
                  state_r  <= ST_IDLE;
               end else if (RDATA_OUT[STAT_READY_BIT]) begin
                  // machine finished; fold its error bits in
                  poll_r   <= 1'b0;
                  WP_OUT   <= 1'b0;
                  ERR_OUT  <= |(RDATA_OUT[7:0] & STAT_ERR_MASK);
                  DONE_OUT <= 1'b1;
                  BUSY_OUT <= 1'b0;
                  state_r  <= ST_IDLE;
               end else begin
                  CE_N_OUT <= 1'b0;
                  OE_N_OUT <= 1'b0;
                  cnt_r    <= RD_CYC - 8'h01;
                  state_r  <= ST_RDLO;
               end
            end
            ST_RSTLO: begin
               if (cnt_r == 8'h00) begin
                  RESET_POWERDOWN_N_OUT <= 1'b1;
                  cnt_r   <= WAKE_CYC - 8'h01;
                  state_r <= ST_RSTWK;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ST_RSTWK: begin
               if (cnt_r == 8'h00) begin
                  // part comes back in read-array mode by itself
                  MODE_OUT <= MODE_ARRAY;
                  WP_OUT   <= 1'b0;
                  DONE_OUT <= 1'b1;
                  BUSY_OUT <= 1'b0;
                  state_r  <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            default: begin
               state_r  <= ST_IDLE;
               BUSY_OUT <= 1'b0;
            end
         endcase
      end
   end

   // checks on the pin sequencing
   no_bus_fight_a: assert property (
      !(OE_N_OUT == 1'b0 && WE_N_OUT == 1'b0))
      else $error("output and write enables low together");
   drive_no_read_a: assert property (
      (DQ_OE_OUT != 16'h0000) |-> OE_N_OUT)
      else $error("host drives data while device outputs enabled");
   byte_lanes_a: assert property (
      (state_r == ST_WELO && byte_r) |-> DQ_OE_OUT[15:8] == 8'h00)
      else $error("upper lanes driven on byte part");
   id_address_a: assert property (
      (state_r == ST_RDLO && MODE_OUT == MODE_ID && !poll_r)
      |-> ADDR_OUT[21:1] == 21'h000000)
      else $error("identifier read with upper address set");
   wp_held_a: assert property (
      (state_r == ST_WELO && poll_r) |-> WP_OUT)
      else $error("write protect low during program or erase");
   lockout_refuse_a: assert property (
      (state_r == ST_IDLE && REQ_IN && !vpp_s2_r &&
       (REQ_DATA_IN.op == OP_PROGRAM || REQ_DATA_IN.op == OP_ERASE))
      |=> DONE_OUT && ERR_OUT && CE_N_OUT)
      else $error("program or erase not refused under lockout");
   reset_array_a: assert property (
      (state_r == ST_RSTWK && cnt_r == 8'h00)
      |=> MODE_OUT == MODE_ARRAY && DONE_OUT)
      else $error("mode not read array after reset");
   reset_width_a: assert property (
      $fell(RESET_POWERDOWN_N_OUT)
      |-> !RESET_POWERDOWN_N_OUT [*3] ##1 RESET_POWERDOWN_N_OUT)
      else $error("reset pulse not three cycles");
   we_rise_a: assert property (
      $rose(WE_N_OUT) |-> !CE_N_OUT && DQ_OE_OUT != 16'h0000
      ##1 CE_N_OUT)
      else $error("write edge without data or select");
   mode_cmd_a: assert property (
      $changed(MODE_OUT) |-> $past(state_r) inside
      {ST_GAP, ST_RSTWK})
      else $error("mode changed without a command");
endmodule

// ---- test/flash_dev_model.sv ----
`timescale 1ns/1ns
// behavioural flash part facing the host; no clock, edge driven
module flash_dev_model #(
   parameter int          ACC_NS  = 60,       // output valid delay
   parameter int          BUSY_NS = 1500,     // program or erase time
   parameter logic [15:0] MFR_ID  = 16'h00a5, // arbitrary value
   parameter logic [15:0] DEV_ID  = 16'h0c3c, // arbitrary value
   parameter logic [15:0] QRY_W   = 16'h005a  // arbitrary value
) (
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        rp_n_in,
   input  wire logic        wp_in,
   input  wire logic        vpp_ok_in,
   input  wire logic        byte_in,
   input  wire logic [21:0] addr_in,
   input  wire logic [15:0] host_dq_in,
   input  wire logic [15:0] host_oe_in,
   output logic      [15:0] dq_out
);
   import flash_host_pkg::*;

   logic [15:0] mem [int];  // sparse array, absent words read erased
   mode_t       mode_r;     // current read mode
   logic [7:0]  sr_r;       // status byte
   logic [7:0]  pend_r;     // command awaiting its second pulse
   logic        busy_r;     // write_state_machine running
   logic        er_r;       // pending work is an erase
   int          tok_r;      // bumped by reset to abort work
   logic [21:0] op_a;       // latched address
   logic [15:0] op_d;       // latched data
   logic [15:0] dev_v;      // word the part would present
   logic [15:0] dev_oe;     // lanes the part drives
   logic [15:0] last_r;     // last driven level of each lane
   wire  [15:0] drv;
   wire  [15:0] val;
   wire         en;
   event        go;

   function automatic logic [15:0] rdmem(int a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction

   // power-up state is read array with a ready status
   initial begin
      mode_r = MODE_ARRAY;
      sr_r   = 8'h80;
      pend_r = 8'h00;
      busy_r = 1'b0;
      tok_r  = 0;
      last_r = 16'h0000;
   end

   // reset floats outputs and kills any running work
   always @(negedge rp_n_in) begin
      mode_r = MODE_ARRAY;
      sr_r   = 8'h80;
      pend_r = 8'h00;
      busy_r = 1'b0;
      tok_r++;
   end

   // commands and operands are taken on the rising write edge
   always @(posedge we_n_in) begin
      if (rp_n_in && !ce_n_in && oe_n_in) begin
         if (busy_r) begin
            // only a status request is answered while busy
            if (host_dq_in[7:0] == 8'h70) mode_r = MODE_STATUS;
         end else if (pend_r != 8'h00) begin
            op_a   = addr_in;
            op_d   = host_dq_in;
            er_r   = (pend_r == CMD_ERASE);
            pend_r = 8'h00;
            if (!vpp_ok_in) begin
               sr_r = er_r ? 8'ha8 : 8'h98;
            end else if (!wp_in && addr_in < 22'h2000) begin
               sr_r = er_r ? 8'ha2 : 8'h92;
            end else if (er_r && op_d[7:0] != 8'hd0) begin
               sr_r = 8'hb0;
            end else begin
               busy_r = 1'b1;
               sr_r   = 8'h00;
               -> go;
            end
         end else begin
            case (host_dq_in[7:0])
               8'hff: mode_r = MODE_ARRAY;
               8'h90: mode_r = MODE_ID;
               8'h70: mode_r = MODE_STATUS;
               8'h98: mode_r = MODE_QUERY;
               8'h50: sr_r   = 8'h80;
               CMD_PROGRAM, CMD_ERASE: begin
                  pend_r = host_dq_in[7:0];
                  mode_r = MODE_STATUS;
               end
               default: ;
            endcase
         end
      end
   end

   // internal timed work; a reset in between discards it
   always @(go) begin
      int t;
      int lo;
      int sz;
      int q [$];
      t = tok_r;
      q.delete();
      #(BUSY_NS);
      if (t == tok_r) begin
         if (er_r) begin
            sz = (op_a < 22'h8000) ? PARAM_WORDS : MAIN_WORDS;
            lo = int'(op_a) & ~(sz - 1);
            foreach (mem[k]) if (k >= lo && k < lo + sz) q.push_back(k);
            foreach (q[i]) mem.delete(q[i]);
         end else begin
            mem[int'(op_a)] = rdmem(int'(op_a)) & op_d;
         end
         sr_r   = 8'h80;
         busy_r = 1'b0;
      end
   end

   // word presented in the current read mode
   always @(mode_r, addr_in, sr_r, busy_r, tok_r) begin
      case (mode_r)
         MODE_ARRAY:  dev_v = rdmem(int'(addr_in));
         MODE_ID:     dev_v = (addr_in[21:1] != 21'h0) ? 16'h0000 :
                              (addr_in[0] ? DEV_ID : MFR_ID);
         MODE_STATUS: dev_v = {8'h00, sr_r};
         default:     dev_v = QRY_W;
      endcase
   end

   // drive only in a read cycle, low lanes only on byte parts
   assign en = rp_n_in & ~ce_n_in & ~oe_n_in & we_n_in;
   assign #(ACC_NS) dev_oe = en ? (byte_in ? 16'h00ff : 16'hffff)
                                : 16'h0000;

   // released lanes show the inverse of their last level
   assign drv = host_oe_in | dev_oe;
   assign val = (host_oe_in & host_dq_in) | (~host_oe_in & dev_v);
   always @(drv, val) last_r = (drv & val) | (~drv & last_r);
   assign dq_out = (drv & val) | (~drv & ~last_r);
endmodule

// ---- test/tb_flash_host.sv ----
`timescale 1ns/1ns
module tb_flash_host;
   import flash_host_pkg::*;

   localparam logic [15:0] MFR = 16'h00a5; // arbitrary value
   localparam logic [15:0] DEV = 16'h0c3c; // arbitrary value
   localparam logic [15:0] QRY = 16'h005a; // arbitrary value

   logic        clk, rst, req, byte_m, vpp;    // bench-driven inputs
   req_t        req_d;                         // request carrier
   logic [15:0] dq_bus, rdata, dq, dq_oe;      // data paths
   logic        busy, done, err, ce_n, oe_n;   // host outputs
   logic        we_n, rp_n, wp;
   mode_t       mode;
   logic [21:0] addr;
   int          n_errors, check_count, cyc, tick, ce_hits;

   flash_host uut (
      .CLK_IN(clk), .RST_IN(rst), .REQ_IN(req), .REQ_DATA_IN(req_d),
      .BYTE_MODE_IN(byte_m), .VPP_OK_IN(vpp), .DQ_IN(dq_bus),
      .BUSY_OUT(busy), .DONE_OUT(done), .ERR_OUT(err),
      .RDATA_OUT(rdata), .MODE_OUT(mode), .CE_N_OUT(ce_n),
      .OE_N_OUT(oe_n), .WE_N_OUT(we_n), .RESET_POWERDOWN_N_OUT(rp_n),
      .WP_OUT(wp), .ADDR_OUT(addr), .DQ_OUT(dq), .DQ_OE_OUT(dq_oe));

   flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV), .QRY_W(QRY)) dev (
      .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .rp_n_in(rp_n),
      .wp_in(wp), .vpp_ok_in(vpp), .byte_in(byte_m), .addr_in(addr),
      .host_dq_in(dq), .host_oe_in(dq_oe), .dq_out(dq_bus));

   always #20 clk = ~clk;

   task stop_test;
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic bad(input string s);
      n_errors++;
      $display("MISMATCH %0t %s", $time, s);
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) bad($sformatf("got %h expected %h", g, e));
   endtask

   // hang guard, and pin-level watch of every cycle
   always @(posedge clk) begin
      tick++;
      if (tick == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (!ce_n) ce_hits++;
      if (!oe_n && !we_n) bad("output and write enables both low");
      if (!oe_n && dq_oe !== 16'h0000) bad("host drives in a read");
   end

   // one request, waits for its completion pulse
   task automatic req_op(input op_t o, input mode_t m,
                         input logic [21:0] a, input logic [15:0] d);
      @(negedge clk);
      req   = 1'b1;
      req_d = {o, m, a, d};
      @(negedge clk);
      req = 1'b0;
      cyc = 0;
      while (done !== 1'b1 && cyc < 600) begin
         @(negedge clk);
         cyc++;
      end
      if (cyc >= 600) bad("no completion");
      chk({15'h0, busy}, 16'h0000);
   endtask

   task automatic rd(input logic [21:0] a, input logic [15:0] e);
      req_op(OP_READ, MODE_ARRAY, a, 16'h0000);
      chk(rdata, e);
   endtask

   // program or erase, expecting success and status mode after
   task automatic alter(input op_t o, input logic [21:0] a,
                        input logic [15:0] d);
      req_op(o, MODE_ARRAY, a, d);
      chk({15'h0, err}, 16'h0000);
      chk({15'h0, wp}, 16'h0000);
      chk({14'h0, mode}, {14'h0, MODE_STATUS});
   endtask

   task automatic set_mode(input mode_t m, input logic [7:0] c);
      req_op(OP_SETMODE, m, 22'h0, {8'h00, c});
      chk({14'h0, mode}, {14'h0, m});
   endtask

   // reset by the bench, then a plain array read without command
   task automatic t_reset(input logic [15:0] e5);
      @(negedge clk);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      cyc = 0;
      while (done !== 1'b1 && cyc < 100) begin
         @(negedge clk);
         cyc++;
      end
      chk({15'h0, rp_n}, 16'h0001);
      chk({14'h0, mode}, {14'h0, MODE_ARRAY});
      rd(22'h5, e5);
   endtask

   // programs in two parameter blocks and two main blocks
   task automatic t_prog;
      alter(OP_PROGRAM, 22'h0005, 16'h1234);
      alter(OP_PROGRAM, 22'h1005, 16'h5678);
      alter(OP_PROGRAM, 22'h8003, 16'habcd);
      alter(OP_PROGRAM, 22'h10000, 16'h0f0f);
      set_mode(MODE_ARRAY, 8'hff);
      rd(22'h1005, 16'h5678);
   endtask

   // erase one block of each size, neighbours must survive
   task automatic t_erase;
      alter(OP_ERASE, 22'h1000, 16'h00d0);
      alter(OP_ERASE, 22'h8000, 16'h00d0);
      set_mode(MODE_ARRAY, 8'hff);
      rd(22'h0005, 16'h1234);
      rd(22'h1005, 16'hffff);
      rd(22'h8003, 16'hffff);
      rd(22'h10000, 16'h0f0f);
   endtask

   // every read mode entered by command, then read
   task automatic t_modes;
      mode_t       tm [5] = '{MODE_ID, MODE_ID, MODE_QUERY, MODE_ARRAY,
                              MODE_STATUS};
      logic [7:0]  tc [5] = '{8'h90, 8'h90, 8'h98, 8'hff, 8'h70};
      logic [21:0] ta [5] = '{22'h100, 22'h1, 22'h10, 22'h5, 22'h0};
      logic [15:0] te [5] = '{MFR, DEV, QRY, 16'h1234, 16'h0080};
      for (int i = 0; i < 5; i++) begin
         set_mode(tm[i], tc[i]);
         rd(ta[i], te[i]);
      end
   endtask

   // supply below lockout: refused at once, no bus cycle
   task automatic t_vpp;
      vpp = 1'b0;
      repeat (4) @(negedge clk);
      ce_hits = 0;
      req_op(OP_PROGRAM, MODE_ARRAY, 22'h0006, 16'h0000);
      chk(cyc[15:0], 16'h0000);
      chk({15'h0, err}, 16'h0001);
      chk(ce_hits[15:0], 16'h0000);
      vpp = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // plain write, then a device reset asked for through the port
   task automatic t_cmd_reset;
      set_mode(MODE_STATUS, 8'h70);
      req_op(OP_WRITE, MODE_ARRAY, 22'h0, 16'h0050);
      chk(cyc[15:0], {8'h00, WE_CYC + 8'h03});
      chk({14'h0, mode}, {14'h0, MODE_STATUS});
      req_op(OP_RESET, MODE_ARRAY, 22'h0, 16'h0000);
      chk(cyc[15:0], {8'h00, RST_CYC + WAKE_CYC});
      chk({14'h0, mode}, {14'h0, MODE_ARRAY});
      rd(22'h5, 16'h1234);
   endtask

   // byte part: upper lanes float and must read as zero
   task automatic t_byte;
      byte_m = 1'b1;
      set_mode(MODE_ARRAY, 8'hff);
      rd(22'h0005, 16'h0034);
      byte_m = 1'b0;
   endtask

   initial begin
      clk         = 1'b0;
      rst         = 1'b1;
      req         = 1'b0;
      req_d       = '0;
      byte_m      = 1'b0;
      vpp         = 1'b1;
      n_errors    = 0;
      check_count = 0;
      tick        = 0;
      ce_hits     = 0;
      t_reset(16'hffff);
      t_prog();
      t_erase();
      t_modes();
      t_reset(16'h1234);
      t_vpp();
      t_cmd_reset();
      t_byte();
      stop_test();
   end
endmodule
